// ==== logic/ttp_pkg.sv ====
// ttp_pkg: register map, field layout and reset values of the triple timer unit
// assumes a 32-bit axi4-lite slave with word-aligned registers
package ttp_pkg;
   // ------------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFF_MODE0   = 8'h00; // first_timer_mode_register
   localparam logic [7:0] OFF_MODE1   = 8'h04; // second_timer_mode_register
   localparam logic [7:0] OFF_MODE2   = 8'h08;
   localparam logic [7:0] OFF_LIMA0   = 8'h0c;
   localparam logic [7:0] OFF_LIMB0   = 8'h10;
   localparam logic [7:0] OFF_LIMA1   = 8'h14;
   localparam logic [7:0] OFF_LIMB1   = 8'h18;
   localparam logic [7:0] OFF_LIMA2   = 8'h1c;
   localparam logic [7:0] OFF_COUNT0  = 8'h20;
   localparam logic [7:0] OFF_COUNT1  = 8'h24;
   localparam logic [7:0] OFF_COUNT2  = 8'h28;
   localparam logic [7:0] OFF_SYSCFG  = 8'h2c; // system_config_register
   localparam logic [7:0] OFF_STATUS  = 8'h30;
   localparam logic [7:0] OFF_MASK    = 8'h34;
   // ------------------------------------------------------------------
   // mode register fields
   // ------------------------------------------------------------------
   localparam int MODE_EN    = 0; // timer runs
   localparam int MODE_CONT  = 1; // restart after final limit
   localparam int MODE_ALT   = 2; // use both limits a and b
   localparam int MODE_PRE   = 3; // count on prescaler_capable_timer events
   localparam int MODE_W     = 4;
   // system config fields
   localparam int CFG_PWD    = 0; // pulse_width_demod_enable
   // status bits
   localparam int ST_T0      = 0;
   localparam int ST_T1      = 1;
   localparam int ST_T2      = 2;
   localparam int ST_RISE    = 3;
   localparam int ST_FALL    = 4;
   localparam int ST_W       = 5;
   // count tick divider: quarter of the processor clock
   localparam int TICK_DIV   = 4;
   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   localparam logic [15:0] LIMIT_RST = 16'hffff;
endpackage : ttp_pkg

// ==== logic/ttp_top.sv ====
// ttp_top: three 16-bit timers with pwm outputs, prescaling and demodulation
// assumes clk_in is the processor clock and cpu_slow_in marks power-save
// ticks; demod_in is an asynchronous pin
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1: counters advance at quarter processor clock
// RULE2: power-save slows counters with processor clock
// RULE3: per-timer mode register selects behaviour
// RULE4: timers 0,1 high to limit a, low to b
// RULE5: third timer has single limit only
// RULE6: third timer output can prescale others
// RULE7: interrupt when count reaches full count
// RULE8: demodulation bit gives interrupts on both edges
// RULE9: counts readable while running
// RULE10: continuous mode restarts from zero, phase a
module ttp_top #(
   parameter int CW = 16
) (
   input  wire logic          clk_in,
   input  wire logic          resetn_in,
   input  wire logic          cpu_slow_in,  // high: processor clock halted this cycle
   input  wire logic          demod_in,
   output logic [2:0]         timer_out,
   output logic               irq_out,
   input  wire logic [7:0]    s_axi_awaddr,
   input  wire logic          s_axi_awvalid,
   output logic               s_axi_awready,
   input  wire logic [31:0]   s_axi_wdata,
   input  wire logic [3:0]    s_axi_wstrb,
   input  wire logic          s_axi_wvalid,
   output logic               s_axi_wready,
   output logic [1:0]         s_axi_bresp,
   output logic               s_axi_bvalid,
   input  wire logic          s_axi_bready,
   input  wire logic [7:0]    s_axi_araddr,
   input  wire logic          s_axi_arvalid,
   output logic               s_axi_arready,
   output logic [31:0]        s_axi_rdata,
   output logic [1:0]         s_axi_rresp,
   output logic               s_axi_rvalid,
   input  wire logic          s_axi_rready
);
   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic [ttp_pkg::MODE_W-1:0] mode [3];
   logic [CW-1:0]              lim_a [3];
   logic [CW-1:0]              lim_b [3];
   logic [CW-1:0]              count [3];
   logic [2:0]                 phase_b;
   logic [2:0]                 done;
   logic [2:0]                 hit;
   logic [2:0]                 step;
   logic [1:0]                 div;
   logic                       tick;
   logic                       demod_enable;
   logic [ttp_pkg::ST_W-1:0]   status;
   logic [ttp_pkg::ST_W-1:0]   mask;
   logic [ttp_pkg::ST_W-1:0]   events;
   logic [2:0]                 dm_sync;
   logic [7:0]                 aw_addr;
   logic [31:0]                w_data;
   logic                       aw_held;
   logic                       w_held;
   logic                       wr_go;
   logic [ttp_pkg::ST_W-1:0]   clr_bits;

   // byte enable merge for a 32-bit write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // ------------------------------------------------------------------
   // count tick: quarter rate, frozen while processor clock is slowed
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         div <= 2'h0;
      end else if (!cpu_slow_in) begin // RULE2
         div <= div + 2'h1; // RULE1
      end
   end
   assign tick = !cpu_slow_in && (div == 2'(ttp_pkg::TICK_DIV - 1)); // RULE1 RULE2

   // ------------------------------------------------------------------
   // timers
   // ------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : gen_tmr
         logic [CW-1:0] limit;
         logic          use_b;
         assign use_b = (g != 2) && mode[g][ttp_pkg::MODE_ALT]; // RULE5
         assign limit = phase_b[g] ? lim_b[g] : lim_a[g];
         // timer 2 never prescales itself
         assign step[g] = (g != 2 && mode[g][ttp_pkg::MODE_PRE]) ? hit[2] : tick; // RULE6
         assign hit[g] = mode[g][ttp_pkg::MODE_EN] && !done[g] && step[g]
                         && (count[g] == limit); // RULE7
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               count[g]   <= '0;
               phase_b[g] <= 1'b0;
               done[g]    <= 1'b0;
            end else if (!mode[g][ttp_pkg::MODE_EN]) begin // RULE3
               done[g]    <= 1'b0;
               phase_b[g] <= 1'b0;
            end else if (hit[g]) begin
               count[g] <= '0;
               if (use_b && !phase_b[g]) begin
                  phase_b[g] <= 1'b1; // RULE4
               end else begin
                  phase_b[g] <= 1'b0; // RULE10
                  done[g]    <= !mode[g][ttp_pkg::MODE_CONT];
               end
            end else if (step[g] && !done[g]) begin
               count[g] <= count[g] + CW'(1);
            end
         end
         // high during phase a, low during phase b
         always_ff @(posedge clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               timer_out[g] <= 1'b0;
            end else begin
               timer_out[g] <= mode[g][ttp_pkg::MODE_EN] && !done[g]
                               && !(use_b && phase_b[g]); // RULE4
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // demodulation input sync and edge events
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         dm_sync <= 3'h0;
      end else begin
         dm_sync <= {dm_sync[1:0], demod_in};
      end
   end
   always_comb begin
      events = '0;
      events[ttp_pkg::ST_T0]   = hit[0]; // RULE7
      events[ttp_pkg::ST_T1]   = hit[1];
      events[ttp_pkg::ST_T2]   = hit[2];
      events[ttp_pkg::ST_RISE] = demod_enable && dm_sync[1] && !dm_sync[2]; // RULE8
      events[ttp_pkg::ST_FALL] = demod_enable && !dm_sync[1] && dm_sync[2]; // RULE8
   end

   // ------------------------------------------------------------------
   // axi4-lite write path
   // ------------------------------------------------------------------
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_go = aw_held && w_held && !s_axi_bvalid;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= ttp_pkg::AXI_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= merge(32'h0, s_axi_wdata, s_axi_wstrb);
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr > ttp_pkg::OFF_MASK || aw_addr[1:0] != 2'h0)
                            ? ttp_pkg::AXI_SLVERR : ttp_pkg::AXI_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         for (int i = 0; i < 3; i++) begin
            mode[i]  <= '0;
            lim_a[i] <= ttp_pkg::LIMIT_RST;
            lim_b[i] <= ttp_pkg::LIMIT_RST;
         end
         demod_enable <= 1'b0;
         mask         <= '0;
      end else if (wr_go) begin
         case (aw_addr)
            ttp_pkg::OFF_MODE0:  mode[0]  <= w_data[ttp_pkg::MODE_W-1:0]; // RULE3
            ttp_pkg::OFF_MODE1:  mode[1]  <= w_data[ttp_pkg::MODE_W-1:0];
            ttp_pkg::OFF_MODE2:  mode[2]  <= w_data[ttp_pkg::MODE_W-1:0];
            ttp_pkg::OFF_LIMA0:  lim_a[0] <= w_data[CW-1:0];
            ttp_pkg::OFF_LIMB0:  lim_b[0] <= w_data[CW-1:0];
            ttp_pkg::OFF_LIMA1:  lim_a[1] <= w_data[CW-1:0];
            ttp_pkg::OFF_LIMB1:  lim_b[1] <= w_data[CW-1:0];
            ttp_pkg::OFF_LIMA2:  lim_a[2] <= w_data[CW-1:0];
            ttp_pkg::OFF_SYSCFG: demod_enable <= w_data[ttp_pkg::CFG_PWD]; // RULE8
            ttp_pkg::OFF_MASK:   mask <= w_data[ttp_pkg::ST_W-1:0];
            default: ;
         endcase
      end
   end

   // sticky status, write one to clear, set wins
   assign clr_bits = (wr_go && aw_addr == ttp_pkg::OFF_STATUS)
                     ? w_data[ttp_pkg::ST_W-1:0] : '0;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         status <= '0;
      end else begin
         status <= (status & ~clr_bits) | events;
      end
   end
   assign irq_out = |(status & mask); // RULE7 RULE8

   // ------------------------------------------------------------------
   // axi4-lite read path
   // ------------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= ttp_pkg::AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= ttp_pkg::AXI_OKAY;
         s_axi_rdata  <= 32'h0;
         case (s_axi_araddr)
            ttp_pkg::OFF_MODE0:  s_axi_rdata <= 32'(mode[0]);
            ttp_pkg::OFF_MODE1:  s_axi_rdata <= 32'(mode[1]);
            ttp_pkg::OFF_MODE2:  s_axi_rdata <= 32'(mode[2]);
            ttp_pkg::OFF_LIMA0:  s_axi_rdata <= 32'(lim_a[0]);
            ttp_pkg::OFF_LIMB0:  s_axi_rdata <= 32'(lim_b[0]);
            ttp_pkg::OFF_LIMA1:  s_axi_rdata <= 32'(lim_a[1]);
            ttp_pkg::OFF_LIMB1:  s_axi_rdata <= 32'(lim_b[1]);
            ttp_pkg::OFF_LIMA2:  s_axi_rdata <= 32'(lim_a[2]);
            ttp_pkg::OFF_COUNT0: s_axi_rdata <= 32'(count[0]); // RULE9
            ttp_pkg::OFF_COUNT1: s_axi_rdata <= 32'(count[1]); // RULE9
            ttp_pkg::OFF_COUNT2: s_axi_rdata <= 32'(count[2]); // RULE9
            ttp_pkg::OFF_SYSCFG: s_axi_rdata <= 32'(demod_enable);
            ttp_pkg::OFF_STATUS: s_axi_rdata <= 32'(status);
            ttp_pkg::OFF_MASK:   s_axi_rdata <= 32'(mask);
            default:             s_axi_rresp <= ttp_pkg::AXI_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   tick_rate_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE1
      tick |=> !tick [*3]) else $error("tick faster than quarter rate");
   slow_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE2
      cpu_slow_in |-> !tick ##1 $stable(count[0])) else $error("count moved in power save");
   mode_off_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE3
      !mode[0][ttp_pkg::MODE_EN] |=> $stable(count[0])) else $error("disabled timer counted");
   pwm_level_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE4
      mode[0][ttp_pkg::MODE_EN] && mode[0][ttp_pkg::MODE_ALT] && !done[0] && phase_b[0]
      |=> !timer_out[0]) else $error("pwm high in phase b");
   single_lim_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE5
      !phase_b[2]) else $error("third timer entered phase b");
   presc_step_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE6
      mode[1][ttp_pkg::MODE_PRE] && !hit[2] |=> $stable(count[1]))
      else $error("prescaled timer stepped without source");
   full_irq_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE7
      hit[0] |=> status[ttp_pkg::ST_T0] && count[0] == '0) else $error("no flag at full count");
   demod_edge_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE8
      $past(demod_enable) && $rose(dm_sync[2]) |-> status[ttp_pkg::ST_RISE])
      else $error("rising edge lost");
   demod_fall_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE8
      $past(demod_enable) && $fell(dm_sync[2]) |-> status[ttp_pkg::ST_FALL])
      else $error("falling edge lost");
   cont_restart_a: assert property (@(posedge clk_in) disable iff (!resetn_in) // RULE10
      hit[1] && mode[1][ttp_pkg::MODE_CONT] && (phase_b[1] || !mode[1][ttp_pkg::MODE_ALT])
      |=> !phase_b[1] && !done[1]) else $error("continuous timer stopped");
   cnt_read_c: cover property (@(posedge clk_in) s_axi_arvalid && s_axi_arready
      && s_axi_araddr == ttp_pkg::OFF_COUNT0 && count[0] != '0); // RULE9
   pwm_cycle_c: cover property (@(posedge clk_in) hit[0] && phase_b[0]);
   presc_c: cover property (@(posedge clk_in) hit[1] && mode[1][ttp_pkg::MODE_PRE]);
   irq_c: cover property (@(posedge clk_in) $rose(irq_out));
   slow_c: cover property (@(posedge clk_in) cpu_slow_in && count[0] != '0);
endmodule : ttp_top
`default_nettype wire

// ==== bench/ttp_top_test.sv ====
// ttp_top_test: self-checking bench for the triple timer unit
// assumes ttp_pkg and ttp_top compiled first; the bench drives every port itself
`timescale 1ns/1ps
`default_nettype none
module ttp_top_test;
   // ------------------------------------------------------------------
   // signals and constants
   // ------------------------------------------------------------------
   logic        clk_in = 1'b0;
   logic        cpu_slow_in = 1'b0;
   logic        resetn_in, demod_in, slow_mode;
   logic [2:0]  timer_out;
   logic        irq_out, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rsp;
   int          mismatches, n_compared, len, la, lb, l2;
   localparam logic [31:0] EN = 32'h1 << ttp_pkg::MODE_EN;
   localparam logic [31:0] CONT = 32'h1 << ttp_pkg::MODE_CONT;
   localparam logic [31:0] ALT = 32'h1 << ttp_pkg::MODE_ALT;
   localparam logic [31:0] PRE = 32'h1 << ttp_pkg::MODE_PRE;
   localparam logic [31:0] RISE = 32'h1 << ttp_pkg::ST_RISE;
   localparam logic [31:0] FALL = 32'h1 << ttp_pkg::ST_FALL;

   ttp_top DUT (
      .clk_in(clk_in), .resetn_in(resetn_in), .cpu_slow_in(cpu_slow_in),
      .demod_in(demod_in), .timer_out(timer_out), .irq_out(irq_out),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   // ------------------------------------------------------------------
   // clock and power-save stall pattern
   // ------------------------------------------------------------------
   always #4 clk_in = ~clk_in;
   // stall every other cycle while slow_mode is set
   always @(posedge clk_in) begin
      cpu_slow_in <= slow_mode ? ~cpu_slow_in : 1'b0;
   end

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------
   task automatic end_sim;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // cycles a phase lasts: limit+1 steps of one tick each
   function automatic int phase_cycles(input int lim, input int factor);
      return (lim + 1) * ttp_pkg::TICK_DIV * factor;
   endfunction : phase_cycles

   // one write, address and data offered together
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk_in);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 200);
      r = bresp;
      bready <= 1'b0;
      if (n >= 200) begin
         mismatches++;
         end_sim();
      end
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 200);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (n >= 200) begin
         mismatches++;
         end_sim();
      end
   endtask : axi_read

   // length of a whole run of level v on timer output i; a run under way
   // may have begun mid-tick, so one full run of the other level goes first
   task automatic run_len(input int i, input logic v, output int l);
      int n;
      n = 0;
      l = 0;
      while (timer_out[i] !== v && n < 3000) begin
         @(posedge clk_in);
         n++;
      end
      while (timer_out[i] !== ~v && n < 3000) begin
         @(posedge clk_in);
         n++;
      end
      while (timer_out[i] !== v && n < 3000) begin
         @(posedge clk_in);
         n++;
      end
      while (timer_out[i] === v && n < 3000) begin
         @(posedge clk_in);
         n++;
         l++;
      end
      if (n >= 3000) begin
         mismatches++;
         end_sim();
      end
   endtask : run_len

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      {resetn_in, demod_in, slow_mode} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hf;
      mismatches = 0;
      n_compared = 0;
      void'($urandom(32'hb749));
      repeat (5) @(posedge clk_in);
      resetn_in <= 1'b1;
      check("reset outputs", {28'h0, timer_out, irq_out}, 32'h0);
      axi_read(ttp_pkg::OFF_LIMA0, rd, rsp);
      check("limit reset", rd, {16'h0, ttp_pkg::LIMIT_RST});
      axi_read(ttp_pkg::OFF_MODE0, rd, rsp);
      check("mode reset", rd, 32'h0);
      axi_read(8'h3c, rd, rsp);
      check("unmapped read", {rsp, rd[29:0]}, {ttp_pkg::AXI_SLVERR, 30'h0});
      axi_write(8'h40, 32'h1, rsp);
      check("unmapped write", 32'(rsp), 32'(ttp_pkg::AXI_SLVERR));
      // demodulation edges, disabled then enabled, with mask and clear
      axi_write(ttp_pkg::OFF_MASK, 32'h1f, rsp);
      for (int e = 0; e < 2; e++) begin
         axi_write(ttp_pkg::OFF_SYSCFG, 32'(e), rsp);
         demod_in <= 1'b1;
         repeat (8) @(posedge clk_in);
         axi_read(ttp_pkg::OFF_STATUS, rd, rsp);
         check("rise status", rd, e ? RISE : 32'h0);
         check("irq raised", 32'(irq_out), 32'(e));
         demod_in <= 1'b0;
         repeat (8) @(posedge clk_in);
         axi_read(ttp_pkg::OFF_STATUS, rd, rsp);
         check("fall status", rd, e ? (RISE | FALL) : 32'h0);
         axi_write(ttp_pkg::OFF_MASK, 32'h0, rsp);
         check("irq masked", 32'(irq_out), 32'h0);
         axi_write(ttp_pkg::OFF_STATUS, 32'h1f, rsp);
         axi_read(ttp_pkg::OFF_STATUS, rd, rsp);
         check("status cleared", rd, 32'h0);
         axi_write(ttp_pkg::OFF_MASK, 32'h1f, rsp);
      end
      // one-shot third timer: count readable mid-run, event, stop
      axi_write(ttp_pkg::OFF_LIMA2, 32'd9, rsp);
      axi_write(ttp_pkg::OFF_MODE2, EN, rsp);
      repeat (16) @(posedge clk_in);
      axi_read(ttp_pkg::OFF_COUNT2, rd, rsp);
      check("count mid-run", 32'(rd > 0 && rd < 10), 32'h1);
      repeat (60) @(posedge clk_in);
      axi_read(ttp_pkg::OFF_STATUS, rd, rsp);
      check("full count event", rd, 32'h1 << ttp_pkg::ST_T2);
      axi_read(ttp_pkg::OFF_COUNT2, rd, rsp);
      check("count after stop", rd, 32'h0);
      check("irq on event", 32'(irq_out), 32'h1);
      axi_write(ttp_pkg::OFF_MODE2, 32'h0, rsp);
      axi_write(ttp_pkg::OFF_STATUS, 32'h1f, rsp);
      // variable duty cycle on the first timer, random limits
      repeat (2) begin
         la = 1 + $urandom % 6;
         lb = 1 + $urandom % 6;
         axi_write(ttp_pkg::OFF_MODE0, 32'h0, rsp);
         axi_write(ttp_pkg::OFF_LIMA0, 32'(la), rsp);
         axi_write(ttp_pkg::OFF_LIMB0, 32'(lb), rsp);
         axi_write(ttp_pkg::OFF_MODE0, EN | CONT | ALT, rsp);
         run_len(0, 1'b1, len);
         check("phase a length", 32'(len), 32'(phase_cycles(la, 1)));
         run_len(0, 1'b0, len);
         check("phase b length", 32'(len), 32'(phase_cycles(lb, 1)));
      end
      // power-save halves the count rate
      slow_mode = 1'b1;
      run_len(0, 1'b1, len);
      check("slow phase a", 32'(len), 32'(phase_cycles(la, 2)));
      slow_mode = 1'b0;
      axi_write(ttp_pkg::OFF_MODE0, 32'h0, rsp);
      // second timer stepped by third timer events
      l2 = 2 + $urandom % 4;
      axi_write(ttp_pkg::OFF_LIMA2, 32'(l2), rsp);
      axi_write(ttp_pkg::OFF_MODE2, EN | CONT | ALT, rsp);
      axi_write(ttp_pkg::OFF_LIMA1, 32'h0, rsp);
      axi_write(ttp_pkg::OFF_LIMB1, 32'h0, rsp);
      axi_write(ttp_pkg::OFF_MODE1, EN | CONT | ALT | PRE, rsp);
      run_len(1, 1'b1, len);
      check("prescaled phase", 32'(len), 32'(phase_cycles(l2, 1)));
      check("third timer level", 32'(timer_out[2]), 32'h1);
      axi_read(ttp_pkg::OFF_STATUS, rd, rsp);
      check("second timer event", rd & 32'h2, 32'h2);
      end_sim();
   end
endmodule : ttp_top_test
`default_nettype wire
